// >>> logic/pcdp_datapath.v
// Data-path steering, memory parity and reset strap capture
// Function
// [RULE1] Transfer direction decoded from action code, refresh, address bit 0, byte-high enable.
// [RULE2] Memory write latches CPU data and drives it onto the memory bus.
// [RULE3] Memory read latches memory bus data and drives it onto CPU bus.
// [RULE4] AT, I/O and ROM transfers in 16 or 8 bits, bytes on matching lanes.
// [RULE5] Matched-width DMA only sets direction between memory and AT buses.
// [RULE6] DMA between 8-bit I/O and 16-bit memory swaps bytes to correct lane.
// [RULE7] Bus master cycles in cache mode only set AT/memory bus direction.
// [RULE8] Each local memory write drives one parity bit per byte.
// [RULE9] Each memory read latches data and parity and compares recomputed parity.
// [RULE10] Byte mismatches ORed and held in a latched parity error flag.
// [RULE11] Parity error flag with interrupt enabled asserts NMI.
// [RULE12] Software clears the parity error flag after diagnosis.
// [RULE13] Board straps the three DMA acknowledge pins for reset sampling.
// [RULE14] Mode strap low selects cache mode, high selects non-cache mode.
// [RULE15] Mode strap level latched into bit 1 of register 40h at reset.
// [RULE16] ROM strap inverted and latched into bit 2 of register 40h.
// [RULE17] Shared pins carry cache signals in cache mode, address 1-15 otherwise.
// [RULE18] Board always straps the internal mode pin low.
// [RULE19] Parity interrupt enable input; flag latches even when disabled.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "pcdp_defines.vh"
module pcdp_datapath (
    clock,
    rst_n,
    action_code,
    refresh_n,
    sa0,
    sbhe_n,
    dma_io_8bit,
    parity_nmi_enable,
    write_data_latch_enable,
    read_data_latch_enable,
    cpu_data_in,
    cpu_data_out,
    cpu_data_oe,
    memory_data_bus_in,
    memory_data_bus_out,
    memory_data_bus_oe,
    memory_parity_bits_in,
    memory_parity_bits,
    sd_data_in,
    sd_data_out,
    sd_data_oe,
    sd_bus_direction_select,
    strap_dack_pins,
    tag_addr_bits,
    tag_write_enable_n,
    cache_addr_bit1,
    cache_byte_select,
    cache_write_enable_n,
    cache_read_enable_n,
    sys_addr_direction_control,
    cpu_addr,
    shared_pins_out,
    cache_mode,
    noncache_mode,
    rom_8bit,
    nmi,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    irq
);
    input wire clock;
    input wire rst_n;
    input wire [3:0] action_code;
    input wire refresh_n;
    input wire sa0;
    input wire sbhe_n;
    input wire dma_io_8bit;
    input wire parity_nmi_enable;
    input wire write_data_latch_enable;
    input wire read_data_latch_enable;
    input wire [15:0] cpu_data_in;
    output reg [15:0] cpu_data_out;
    output wire cpu_data_oe;
    input wire [15:0] memory_data_bus_in;
    output reg [15:0] memory_data_bus_out;
    output wire memory_data_bus_oe;
    input wire [1:0] memory_parity_bits_in;
    output reg [1:0] memory_parity_bits;
    input wire [15:0] sd_data_in;
    output reg [15:0] sd_data_out;
    output wire [1:0] sd_data_oe;
    output reg [1:0] sd_bus_direction_select;
    input wire [2:0] strap_dack_pins;
    input wire [7:0] tag_addr_bits;
    input wire tag_write_enable_n;
    input wire cache_addr_bit1;
    input wire [1:0] cache_byte_select;
    input wire cache_write_enable_n;
    input wire cache_read_enable_n;
    input wire sys_addr_direction_control;
    input wire [15:1] cpu_addr;
    output reg [15:1] shared_pins_out;
    output wire cache_mode;
    output wire noncache_mode;
    output wire rom_8bit;
    output wire nmi;
    input wire [7:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [7:0] reg_rdata;
    output wire irq;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function is_write;
        input [3:0] code;
        begin
            is_write = (code == `PCDP_ACT_MEM_WR) || (code == `PCDP_ACT_AT_WR) ||
                (code == `PCDP_ACT_IO_WR) || (code == `PCDP_ACT_DMA_WR) ||
                (code == `PCDP_ACT_MST_WR);
        end
    endfunction

    function is_at_side;
        input [3:0] code;
        begin
            is_at_side = (code >= `PCDP_ACT_AT_RD) && (code <= `PCDP_ACT_ROM_RD);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Strap synchroniser and capture
    reg [2:0] strap_s1_reg;
    reg [2:0] strap_s2_reg;
    reg [1:0] strap_cnt_reg;
    reg mode_strap_reg;
    reg rom_strap_reg;
    reg straps_done_reg;

    always @(posedge clock) begin
        strap_s1_reg <= strap_dack_pins;
        strap_s2_reg <= strap_s1_reg;
    end

    // Capture happens while reset is held, after the synchroniser has filled
    always @(posedge clock) begin
        if (!rst_n) begin
            if (strap_cnt_reg != 2'h3) begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            end else begin
                // [RULE14] [RULE15] mode strap latch
                mode_strap_reg <= strap_s2_reg[1];
                // [RULE16] inverted ROM strap
                rom_strap_reg <= ~strap_s2_reg[2];
                straps_done_reg <= 1'b1;
            end
        end else begin
            strap_cnt_reg <= 2'h0;
            if (!straps_done_reg) begin
                // Reset too short for capture: take synchronised level at release
                mode_strap_reg <= strap_s2_reg[1];
                rom_strap_reg <= ~strap_s2_reg[2];
                straps_done_reg <= 1'b1;
            end
        end
    end

    // [RULE14] mode decode
    assign cache_mode = ~mode_strap_reg;
    assign noncache_mode = mode_strap_reg;
    assign rom_8bit = rom_strap_reg;

    // [RULE17] shared pin multiplexer
    always @(posedge clock) begin
        if (!rst_n) begin
            shared_pins_out <= 15'h0000;
        end else if (cache_mode) begin
            shared_pins_out <= {sys_addr_direction_control, cache_read_enable_n, cache_write_enable_n,
                cache_byte_select, cache_addr_bit1, tag_write_enable_n, tag_addr_bits};
        end else begin
            shared_pins_out <= cpu_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Direction decode
    wire wr_cycle = is_write(action_code);
    wire dma_cycle = (action_code == `PCDP_ACT_DMA_RD) || (action_code == `PCDP_ACT_DMA_WR);
    wire mst_cycle = (action_code == `PCDP_ACT_MST_RD) || (action_code == `PCDP_ACT_MST_WR);
    // 8-bit cycle on an odd byte, or high byte only: upper lane carries data
    wire high_byte = sa0 & ~sbhe_n;
    wire is_8bit = sa0 | sbhe_n;
    reg cpu_drive;
    reg md_drive;
    reg [1:0] sd_drive;

    always @* begin
        cpu_drive = 1'b0;
        md_drive = 1'b0;
        sd_drive = 2'b00;
        sd_bus_direction_select = `PCDP_SDIR_OFF;
        // [RULE1] refresh blocks all drivers
        if (refresh_n) begin
            case (action_code)
                `PCDP_ACT_MEM_RD: begin
                    cpu_drive = 1'b1;
                end
                `PCDP_ACT_MEM_WR: begin
                    md_drive = 1'b1;
                end
                `PCDP_ACT_AT_RD, `PCDP_ACT_IO_RD, `PCDP_ACT_ROM_RD: begin
                    cpu_drive = 1'b1;
                end
                `PCDP_ACT_AT_WR, `PCDP_ACT_IO_WR: begin
                    // [RULE4] lane enables by width
                    sd_drive = is_8bit ? 2'b01 : 2'b11;
                end
                `PCDP_ACT_DMA_RD, `PCDP_ACT_DMA_WR: begin
                    // [RULE5] direction only
                    sd_bus_direction_select = wr_cycle ? `PCDP_SDIR_TO_MD : `PCDP_SDIR_TO_SD;
                    md_drive = wr_cycle;
                    sd_drive = wr_cycle ? 2'b00 : (dma_io_8bit ? 2'b01 : 2'b11);
                end
                `PCDP_ACT_MST_RD, `PCDP_ACT_MST_WR: begin
                    // [RULE7] master cycles steered only in cache mode
                    if (cache_mode) begin
                        sd_bus_direction_select = wr_cycle ? `PCDP_SDIR_TO_MD : `PCDP_SDIR_TO_SD;
                        md_drive = wr_cycle;
                        sd_drive = wr_cycle ? 2'b00 : 2'b11;
                    end
                end
                default: begin
                    cpu_drive = 1'b0;
                end
            endcase
        end
    end

    assign cpu_data_oe = cpu_drive;
    assign memory_data_bus_oe = md_drive;
    assign sd_data_oe = sd_drive;

    ////////////////////////////////////////////////////////////////////////////////
    // Data latches
    reg [15:0] wr_latch_reg;
    reg [15:0] rd_latch_reg;
    reg [1:0] rd_par_reg;
    reg rd_check_reg;
    wire [1:0] gen_par;
    wire [1:0] chk_par;
    wire chk_mismatch;
    reg [15:0] md_src;

    // Write source: CPU latch, or AT data for DMA and master, swapped for odd-byte 8-bit DMA I/O
    always @* begin
        if (dma_cycle || mst_cycle) begin
            // [RULE6] odd byte moved to upper lane
            md_src = (dma_cycle && dma_io_8bit && sa0) ? {sd_data_in[7:0], sd_data_in[7:0]} : sd_data_in;
        end else begin
            md_src = wr_latch_reg;
        end
    end

    // [RULE8] write parity
    pcdp_parity u_gen (
        .data(md_src),
        .par_in(2'b00),
        .par_out(gen_par),
        .mismatch()
    );

    // [RULE9] check on latched read data
    pcdp_parity u_chk (
        .data(rd_latch_reg),
        .par_in(rd_par_reg),
        .par_out(chk_par),
        .mismatch(chk_mismatch)
    );

    always @(posedge clock) begin
        if (!rst_n) begin
            wr_latch_reg <= 16'h0000;
            rd_latch_reg <= 16'h0000;
            rd_par_reg <= 2'h0;
            rd_check_reg <= 1'b0;
            memory_data_bus_out <= 16'h0000;
            memory_parity_bits <= 2'h0;
            cpu_data_out <= 16'h0000;
            sd_data_out <= 16'h0000;
        end else begin
            // [RULE2] CPU write latch
            if (write_data_latch_enable) begin
                wr_latch_reg <= cpu_data_in;
            end
            memory_data_bus_out <= md_src;
            memory_parity_bits <= gen_par;
            // [RULE3] [RULE9] read latch with parity
            rd_check_reg <= 1'b0;
            if (read_data_latch_enable && refresh_n && !is_at_side(action_code)) begin
                rd_latch_reg <= memory_data_bus_in;
                rd_par_reg <= memory_parity_bits_in;
                rd_check_reg <= 1'b1;
            end
            // [RULE4] CPU read data from memory or AT lanes
            if (is_at_side(action_code)) begin
                cpu_data_out <= high_byte ? {sd_data_in[7:0], sd_data_in[7:0]} : sd_data_in;
            end else begin
                cpu_data_out <= rd_latch_reg;
            end
            // [RULE4] [RULE6] upper byte copied low for odd-byte 8-bit targets
            if (dma_cycle || mst_cycle) begin
                sd_data_out <= (dma_io_8bit && sa0) ? {rd_latch_reg[15:8], rd_latch_reg[15:8]} : rd_latch_reg;
            end else begin
                sd_data_out <= high_byte ? {cpu_data_in[15:8], cpu_data_in[15:8]} : cpu_data_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers, parity flag and interrupt
    reg [7:0] ctrl_reg;
    reg [1:0] status_reg;
    reg [1:0] mask_reg;
    reg [1:0] status_next;
    wire perr_event = rd_check_reg & chk_mismatch;
    // ROM width disagreement with an 8-bit ROM read cycle seen on a 16-bit request
    wire rom_event = (action_code == `PCDP_ACT_ROM_RD) & rom_strap_reg & ~sbhe_n & ~sa0 & refresh_n;

    always @* begin
        status_next = status_reg;
        // [RULE12] write one to clear; set wins
        if (reg_wr && reg_addr == `PCDP_REG_STAT) begin
            status_next = status_reg & ~reg_wdata[1:0];
        end
        // [RULE10] latched error flag
        if (perr_event) begin
            status_next[`PCDP_EV_PERR] = 1'b1;
        end
        if (rom_event) begin
            status_next[`PCDP_EV_ROMBAD] = 1'b1;
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg <= `PCDP_CTRL_RST;
            status_reg <= 2'h0;
            mask_reg <= 2'h0;
            reg_rdata <= 8'h00;
        end else begin
            status_reg <= status_next;
            if (reg_wr && reg_addr == `PCDP_REG_CTRL) begin
                ctrl_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == `PCDP_REG_MASK) begin
                mask_reg <= reg_wdata[1:0];
            end
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `PCDP_REG_CFG: begin
                        reg_rdata <= {5'h00, rom_strap_reg, mode_strap_reg, 1'b0};
                    end
                    `PCDP_REG_CTRL: begin
                        reg_rdata <= ctrl_reg;
                    end
                    `PCDP_REG_STAT: begin
                        reg_rdata <= {6'h00, status_reg};
                    end
                    `PCDP_REG_MASK: begin
                        reg_rdata <= {6'h00, mask_reg};
                    end
                    default: begin
                        reg_rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

    // [RULE11] [RULE19] NMI gated by both enables
    assign nmi = status_reg[`PCDP_EV_PERR] & parity_nmi_enable & ctrl_reg[`PCDP_CTRL_NMIEN_BIT];
    assign irq = |(status_reg & mask_reg);
endmodule // pcdp_datapath

// >>> logic/pcdp_parity.v
// Byte parity generator and checker
`timescale 1ns/1ns
module pcdp_parity (
    data,
    par_in,
    par_out,
    mismatch
);
    input wire [15:0] data;
    input wire [1:0] par_in;
    output wire [1:0] par_out;
    output wire mismatch;
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_byte
            // Even parity per byte
            assign par_out[i] = ^data[8*i+7:8*i];
        end
    endgenerate
    assign mismatch = |(par_out ^ par_in);
endmodule // pcdp_parity

// >>> shared/pcdp_defines.vh
// Constants for the data-path, parity and strap block
`ifndef PCDP_DEFINES_VH
`define PCDP_DEFINES_VH
// Register offsets (8-bit index)
`define PCDP_REG_CFG 8'h40
`define PCDP_REG_CTRL 8'h41
`define PCDP_REG_STAT 8'h42
`define PCDP_REG_MASK 8'h43
// Fields of register 40h
`define PCDP_CFG_MODE_BIT 1
`define PCDP_CFG_ROM_BIT 2
// Status and mask bits
`define PCDP_EV_PERR 0
`define PCDP_EV_ROMBAD 1
// Control fields
`define PCDP_CTRL_NMIEN_BIT 0
// Reset values
`define PCDP_CTRL_RST 8'h01
`define PCDP_MASK_RST 8'h00
// Cycle action codes
`define PCDP_ACT_IDLE 4'h0
`define PCDP_ACT_MEM_RD 4'h1
`define PCDP_ACT_MEM_WR 4'h2
`define PCDP_ACT_AT_RD 4'h3
`define PCDP_ACT_AT_WR 4'h4
`define PCDP_ACT_IO_RD 4'h5
`define PCDP_ACT_IO_WR 4'h6
`define PCDP_ACT_ROM_RD 4'h7
`define PCDP_ACT_DMA_RD 4'h8
`define PCDP_ACT_DMA_WR 4'h9
`define PCDP_ACT_MST_RD 4'ha
`define PCDP_ACT_MST_WR 4'hb
// Direction codes on sd_bus_direction_select
`define PCDP_SDIR_OFF 2'h0
`define PCDP_SDIR_TO_SD 2'h1
`define PCDP_SDIR_TO_MD 2'h2
`endif

// >>> verification/pcdp_datapath_properties.sv
// Assertion checker for the data-path, parity and strap block
`timescale 1ns/1ns
`include "pcdp_defines.vh"
module pcdp_datapath_checker (
    input logic clock,
    input logic rst_n,
    input logic [3:0] action_code,
    input logic refresh_n,
    input logic parity_nmi_enable,
    input logic read_data_latch_enable,
    input logic [15:0] memory_data_bus_in,
    input logic [1:0] memory_parity_bits_in,
    input logic [15:0] cpu_data_out,
    input logic cpu_data_oe,
    input logic [15:0] memory_data_bus_out,
    input logic memory_data_bus_oe,
    input logic [1:0] memory_parity_bits,
    input logic [1:0] sd_data_oe,
    input logic [15:1] cpu_addr,
    input logic [15:1] shared_pins_out,
    input logic cache_mode,
    input logic noncache_mode,
    input logic rom_8bit,
    input logic nmi,
    input logic [7:0] reg_addr,
    input logic reg_rd,
    input logic [7:0] reg_rdata
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Memory read taken this edge, and the parity its data should carry
    wire rd_take = read_data_latch_enable && refresh_n && action_code == `PCDP_ACT_MEM_RD;
    wire [1:0] in_par = {^memory_data_bus_in[15:8], ^memory_data_bus_in[7:0]};
    ////////////////////////////////////////////////////////////////////////////
    a_mode_exclusive: assert property (cache_mode != noncache_mode)
        else $error("mode flags not exclusive");
    a_cfg_readback: assert property (reg_rd && reg_addr == `PCDP_REG_CFG |=>
        reg_rdata == {5'h00, rom_8bit, noncache_mode, 1'h0}) else $error("strap register wrong");
    a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not cleared");
    a_parity_gen: assert property (memory_parity_bits == {^memory_data_bus_out[15:8], ^memory_data_bus_out[7:0]})
        else $error("write parity wrong");
    a_refresh_quiet: assert property (!refresh_n |-> !cpu_data_oe && !memory_data_bus_oe && sd_data_oe == 2'h0)
        else $error("driver on during refresh");
    a_read_capture: assert property (rd_take |=> ##1 cpu_data_out == $past(memory_data_bus_in, 2))
        else $error("read data not passed to cpu");
    a_perr_nmi: assert property (rd_take && parity_nmi_enable && memory_parity_bits_in != in_par |-> ##[2:3] nmi)
        else $error("parity error gave no nmi");
    a_nmi_gate: assert property (nmi |-> parity_nmi_enable) else $error("nmi while disabled");
    a_addr_pins: assert property (noncache_mode |=> shared_pins_out == $past(cpu_addr))
        else $error("shared pins not address");
endmodule // pcdp_datapath_checker
bind pcdp_datapath pcdp_datapath_checker pcdp_datapath_checker_inst (
    .clock, .rst_n, .action_code, .refresh_n, .parity_nmi_enable, .read_data_latch_enable, .memory_data_bus_in,
    .memory_parity_bits_in, .cpu_data_out, .cpu_data_oe, .memory_data_bus_out, .memory_data_bus_oe,
    .memory_parity_bits, .sd_data_oe, .cpu_addr, .shared_pins_out, .cache_mode, .noncache_mode, .rom_8bit,
    .nmi, .reg_addr, .reg_rd, .reg_rdata
);

// >>> verification/pcdp_dram_model.sv
// One local memory word with its byte parity, seen from the memory bus
`timescale 1ns/1ns
module pcdp_dram_model (
    input logic clock,
    input logic [15:0] wdata,
    input logic [1:0] wpar,
    input logic wen,
    input logic fetch,
    input logic spoil,
    output logic [15:0] rdata,
    output logic [1:0] rpar
);
    logic [17:0] cell_reg = 18'h0;
    logic [17:0] last_reg = 18'h0;
    always @(posedge clock) begin
        if (wen) begin
            cell_reg <= {wdata, wpar};
        end
        last_reg <= {rdata, rpar};
    end
    // Released bus toggles so a stale word is never mistaken for data
    assign {rdata, rpar} = fetch ? cell_reg ^ {17'h0, spoil} : ~last_reg;
endmodule // pcdp_dram_model

// >>> verification/tb_pcdp_datapath.sv
// Self-checking bench for the data-path, parity and strap block
`timescale 1ns/1ns
`include "pcdp_defines.vh"
module tb_pcdp_datapath;
    logic clock = 1'h0, rst_n = 1'h0, refresh_n = 1'h1, parity_nmi_enable = 1'h1, fetch = 1'h0, spoil = 1'h0;
    logic write_data_latch_enable = 1'h0, read_data_latch_enable = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic sa0 = 1'h0, dma_io_8bit = 1'h0;
    logic [3:0] action_code = 4'h0;
    logic [2:0] strap_dack_pins = 3'h2;
    logic [14:0] cpins = 15'h0;
    logic [15:1] cpu_addr = 15'h0;
    logic [15:0] cpu_data_in = 16'h0, sd_data_in = 16'h0;
    logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0;
    logic [3:0] dcode [5] = '{`PCDP_ACT_DMA_RD, `PCDP_ACT_DMA_WR, `PCDP_ACT_MST_RD, `PCDP_ACT_MST_WR, `PCDP_ACT_DMA_RD};
    logic [1:0] dexp [5] = '{`PCDP_SDIR_TO_SD, `PCDP_SDIR_TO_MD, `PCDP_SDIR_TO_SD, `PCDP_SDIR_TO_MD, `PCDP_SDIR_OFF};
    wire [15:0] cpu_data_out, memory_data_bus_out, memory_data_bus_in, sd_data_out;
    wire [1:0] memory_parity_bits, memory_parity_bits_in, sd_data_oe, sd_bus_direction_select;
    wire [15:1] shared_pins_out;
    wire [7:0] reg_rdata;
    wire memory_data_bus_oe, cpu_data_oe, cache_mode, noncache_mode, rom_8bit, nmi, irq;
    int checks = 0, miscompares = 0;
    always #50 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////
    pcdp_datapath pcdp_datapath_inst (
        .clock, .rst_n, .action_code, .refresh_n, .sa0, .sbhe_n(1'h0), .dma_io_8bit,
        .parity_nmi_enable, .write_data_latch_enable, .read_data_latch_enable, .cpu_data_in, .cpu_data_out,
        .cpu_data_oe, .memory_data_bus_in, .memory_data_bus_out, .memory_data_bus_oe, .memory_parity_bits_in,
        .memory_parity_bits, .sd_data_in, .sd_data_out, .sd_data_oe, .sd_bus_direction_select, .strap_dack_pins,
        .tag_addr_bits(cpins[7:0]), .tag_write_enable_n(cpins[8]), .cache_addr_bit1(cpins[9]),
        .cache_byte_select(cpins[11:10]), .cache_write_enable_n(cpins[12]), .cache_read_enable_n(cpins[13]),
        .sys_addr_direction_control(cpins[14]), .cpu_addr, .shared_pins_out, .cache_mode, .noncache_mode,
        .rom_8bit, .nmi, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq
    );
    pcdp_dram_model pcdp_dram_model_inst (.clock, .wdata(memory_data_bus_out), .wpar(memory_parity_bits),
        .wen(memory_data_bus_oe), .fetch, .spoil, .rdata(memory_data_bus_in), .rpar(memory_parity_bits_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // The acc and mread tasks start on a rising edge and return mid-cycle
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clock);
        {reg_wr, reg_rd} <= 2'h0;
        @(negedge clock);
        if (!w) chk({8'h0, reg_rdata}, {8'h0, d});
    endtask
    task automatic mread(input logic bad, input logic en);
        @(posedge clock);
        action_code <= `PCDP_ACT_MEM_RD;
        {fetch, spoil, parity_nmi_enable, read_data_latch_enable} <= {1'h1, bad, en, 1'h1};
        @(posedge clock);
        read_data_latch_enable <= 1'h0;
        // Latched word reaches the CPU bus one edge after the latch edge
        @(posedge clock);
        @(negedge clock);
        chk(cpu_data_out, 16'h1347);
        chk({15'h0, cpu_data_oe}, 16'h1);
        repeat (3) @(posedge clock);
        {fetch, action_code} <= 5'h00;
        @(negedge clock);
        chk({14'h0, cpu_data_oe, nmi}, {14'h0, 1'h0, bad & en});
    endtask
    task automatic conclude;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            rst_n <= 1'h0;
            strap_dack_pins <= i ? 3'h4 : 3'h2; // low internal pin
            cpu_addr <= i ? 15'h2a5c : 15'h51a3;
            cpins <= i ? 15'h5a96 : 15'h25e1;
            repeat (16) @(posedge clock);
            rst_n <= 1'h1;
            // Straps move after reset; latched values must not
            strap_dack_pins <= strap_dack_pins ^ 3'h6;
            acc(1'h0, `PCDP_REG_CFG, i ? 8'h00 : 8'h06);
            chk({13'h0, rom_8bit, noncache_mode, cache_mode}, i ? 16'h1 : 16'h6);
            chk({1'h0, shared_pins_out}, i ? 16'h5a96 : 16'h51a3);
            $display("strap pass %0d done", i);
        end
        acc(1'h0, `PCDP_REG_CTRL, `PCDP_CTRL_RST);
        acc(1'h1, `PCDP_REG_CFG, 8'hff);
        acc(1'h0, `PCDP_REG_CFG, 8'h00);
        acc(1'h0, 8'h7f, 8'h00);
        acc(1'h1, `PCDP_REG_MASK, 8'h01);
        acc(1'h0, `PCDP_REG_MASK, 8'h01);
        $display("register pass done");
        for (int k = 0; k < 5; k++) begin
            @(posedge clock);
            action_code <= dcode[k];
            refresh_n <= (k != 4);
            @(negedge clock);
            chk({14'h0, sd_bus_direction_select}, {14'h0, dexp[k]});
        end
        // Odd byte of an 8-bit I/O DMA lands on both memory lanes
        @(posedge clock);
        {refresh_n, action_code, dma_io_8bit, sa0, sd_data_in} <= {1'h1, `PCDP_ACT_DMA_WR, 2'h3, 16'h00c5};
        @(posedge clock);
        action_code <= `PCDP_ACT_DMA_RD;
        @(negedge clock);
        chk(memory_data_bus_out, 16'hc5c5);
        chk({14'h0, sd_data_oe}, 16'h1);
        @(posedge clock);
        {refresh_n, action_code, write_data_latch_enable} <= {1'h1, `PCDP_ACT_AT_WR, 1'h1};
        {dma_io_8bit, sa0} <= 2'h0;
        {cpu_data_in, sd_data_in} <= {16'h6c3a, 16'hb4e1};
        @(posedge clock);
        write_data_latch_enable <= 1'h0;
        repeat (2) @(posedge clock);
        action_code <= `PCDP_ACT_AT_RD;
        @(negedge clock);
        chk(sd_data_out, 16'h6c3a);
        repeat (3) @(posedge clock);
        {action_code, cpu_data_in, write_data_latch_enable} <= {`PCDP_ACT_MEM_WR, 16'h1347, 1'h1};
        @(negedge clock);
        chk(cpu_data_out, 16'hb4e1);
        @(posedge clock);
        write_data_latch_enable <= 1'h0;
        @(posedge clock);
        @(negedge clock);
        chk(memory_data_bus_out, 16'h1347);
        chk({14'h0, memory_parity_bits}, {14'h0, ^cpu_data_in[15:8], ^cpu_data_in[7:0]});
        repeat (2) @(posedge clock);
        action_code <= `PCDP_ACT_IDLE;
        $display("transfer pass done");
        mread(1'h0, 1'h1);
        acc(1'h0, `PCDP_REG_STAT, 8'h00);
        mread(1'h1, 1'h1);
        chk({15'h0, irq}, 16'h1);
        acc(1'h0, `PCDP_REG_STAT, 8'h01);
        acc(1'h1, `PCDP_REG_STAT, 8'h01);
        acc(1'h0, `PCDP_REG_STAT, 8'h00);
        chk({14'h0, irq, nmi}, 16'h0);
        mread(1'h1, 1'h0);
        acc(1'h0, `PCDP_REG_STAT, 8'h01);
        acc(1'h1, `PCDP_REG_MASK, 8'h00);
        chk({15'h0, irq}, 16'h0);
        $display("parity pass done");
        conclude();
    end
    // The tests need some 100 cycles
    initial begin
        repeat (3000) @(posedge clock);
        miscompares++;
        conclude();
    end
endmodule // tb_pcdp_datapath
